// ---- clmj_ahb_master.sv ----
`timescale 1ns/10ps
`default_nettype none
// single-transfer ahb-lite master standing in for the host software
module clmj_ahb_master
    import clmj_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    input  wire logic        hresp,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    // bus idle from time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h0;
        hwdata = 32'h00000000;
    end

    // address phase held until hready, then data phase held until hready
    task automatic xfer(input logic wr, input logic [7:0] off,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic resp);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, off};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= {1'b0, HSIZE_WORD};
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        // release the address phase, present write data
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        // read data and response taken at the closing edge
        rd   = hrdata;
        resp = hresp;
    endtask : xfer
endmodule : clmj_ahb_master
`default_nettype wire

// ---- clmj_core.sv ----
// Function
// - fetch in t1-t3, pc increments in t2
// - c3 jumps to bytes two/three address
// - jump uses latches, pc becomes latch+1
// - 3a loads acc from direct address
// - 0a/1a load acc via pair, 7 cycles
// - 2a fetches address bytes, 16 cycles
// - 2a loads bottom then upper pair
// - latches increment in fourth cycle t2
// - field 110 means memory at pair address
// - immediate store to register or memory
// - immediate store keeps flags
// - or_with_acc ors source into accumulator
// - or sets zero, sign, parity
// - listed instructions keep all flags
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module clmj_core
    import clmj_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [15:0] addr_pins,
    output logic      [7:0]  flags_out
);
    clmj_mem_if mbus ();           // memory channel
    logic [7:0]  acc_q, flag_q;    // accumulator and flags
    logic [7:0]  rf_q [8];         // register file by field code
    logic [15:0] pc_q;             // program counter
    logic [7:0]  ir_q;             // instruction_latch
    logic [7:0]  tmp_q;            // operand latch
    logic [7:0]  alo_q, ahi_q;     // addr_low_latch, addr_high_latch
    logic [7:0]  acc_shadow_q;     // acc_shadow_latch
    logic [2:0]  mcyc_q;           // machine cycle 1..5
    clmj_tstate_t st_q;            // processor state
    logic        run_q;            // software run enable
    logic        or_pend_q;        // or result owed in next t2
    logic        jmp_fetch_q;      // next fetch uses latches
    logic        ap_q, aw_q;       // ahb data phase pending, is write
    logic [7:0]  ao_q;             // latched ahb offset
    logic        ld_we;            // loader write strobe
    logic        is_copy, is_alu_or, is_imm;
    logic [2:0]  dfield, sfield;
    logic [15:0] hl, latch_addr;
    logic [15:0] ab_sel;           // address chosen for this machine cycle
    logic [15:0] ab_q;             // address held on the bus after t1
    logic [7:0]  src_val, or_res;

    // read a register by field code; accumulator lives apart
    function automatic logic [7:0] rd_reg(input logic [2:0] f,
            input logic [7:0] a, input logic [7:0] r [8]);
        rd_reg = (f == R_ACC) ? a : r[f];
    endfunction : rd_reg

    // decode
    assign dfield     = ir_q[5:3];
    assign sfield     = ir_q[2:0];
    assign is_copy    = (ir_q[7:6] == GRP_COPY);
    assign is_alu_or  = (ir_q[7:6] == GRP_ALU) && (ir_q[5:3] == ALU_OR);
    assign is_imm     = (ir_q[7:6] == 2'h0) && (ir_q[2:0] == IMM_LOW);
    assign hl         = {rf_q[R_UP], rf_q[R_BOT]};
    assign latch_addr = {ahi_q, alo_q};
    assign src_val    = rd_reg(sfield, acc_q, rf_q);
    assign or_res     = acc_shadow_q | tmp_q;

    // memory instance
    clmj_mem clmj_mem_inst (
        .core_clk (core_clk),
        .mp       (mbus.mem),
        .ld_we    (ld_we),
        .ld_addr  (hwdata[23:8]),
        .ld_data  (hwdata[7:0])
    );

    // address and write drive per machine cycle; the address chosen in
    // t1 is held afterwards so the pc step in t2 cannot move the t3 read
    always_comb begin
        ab_sel     = pc_q;
        mbus.wdata = tmp_q;
        mbus.we    = 1'b0;
        if (mcyc_q == 3'h1) begin
            ab_sel = jmp_fetch_q ? latch_addr : pc_q;
        end else if (ir_q == OP_LDXB || ir_q == OP_LDXD) begin
            ab_sel = ir_q[4] ? {rf_q[R_D], rf_q[R_E]}
                             : {rf_q[R_B], rf_q[R_C]};
        end else if (ir_q == OP_LDA || ir_q == OP_LHL) begin
            ab_sel = (mcyc_q >= 3'h4) ? latch_addr : pc_q;
        end else if (is_copy || is_alu_or
                     || (is_imm && mcyc_q == 3'h3)) begin
            ab_sel = hl;
            mbus.we = (st_q == ST_T3) && (dfield == R_MEM)
                      && (is_copy || is_imm);
        end
        mbus.addr = (st_q == ST_T1) ? ab_sel : ab_q;
    end

    // ahb loader strobe: write to offset 0 with bit 31 loads memory
    assign ld_we = ap_q && aw_q && (ao_q == OFF_CTRL) && hwdata[31];

    // ahb address phase capture, zero wait state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ap_q <= 1'b0;
            aw_q <= 1'b0;
            ao_q <= 8'h00;
        end else if (hready) begin
            ap_q <= hsel && (htrans == HTRANS_NONSEQ);
            aw_q <= hwrite;
            ao_q <= haddr[7:0];
        end
    end

    // ahb read data, registered on the address phase
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && !hwrite) begin
            case (haddr[7:0])
                OFF_CTRL:   hrdata <= {31'h0000_0000, run_q};
                OFF_STATUS: hrdata <= {10'h000, st_q, mcyc_q,
                                       flag_q, acc_q};
                OFF_PC:     hrdata <= {16'h0000, pc_q};
                OFF_HL:     hrdata <= {16'h0000, hl};
                OFF_BC:     hrdata <= {16'h0000, rf_q[R_B], rf_q[R_C]};
                OFF_DE:     hrdata <= {16'h0000, rf_q[R_D], rf_q[R_E]};
                default:    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ahb ready once out of reset (low during reset), always okay
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // run control register, write stops or starts execution
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (ap_q && aw_q && ao_q == OFF_CTRL && !hwdata[31]) begin
            run_q <= hwdata[0];
        end
    end

    // pin and flag outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_pins <= 16'h0000;
            flags_out <= 8'h00;
        end else begin
            addr_pins <= mbus.addr;
            flags_out <= flag_q;
        end
    end

    // state sequencer: t1..t4 in every fetch, t5 only for register-to-register copies
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= ST_T1;
            mcyc_q <= 3'h1;
        end else if (run_q) begin
            case (st_q)
                ST_T1: st_q <= ST_T2;
                ST_T2: st_q <= ST_T3;
                ST_T3: begin
                    if (mcyc_q == 3'h1) begin
                        st_q <= ST_T4;
                    end else begin
                        st_q <= ST_T1;
                        mcyc_q <= last_cycle() ? 3'h1 : mcyc_q + 3'h1;
                    end
                end
                ST_T4: begin
                    if (is_copy && dfield != R_MEM && sfield != R_MEM) begin
                        st_q <= ST_T5;
                    end else begin
                        st_q <= ST_T1;
                        mcyc_q <= one_cycle() ? 3'h1 : 3'h2;
                    end
                end
                ST_T5: begin
                    st_q <= ST_T1;
                    mcyc_q <= 3'h1;
                end
                default: st_q <= ST_T1;
            endcase
        end
    end

    // single machine cycle instructions
    function automatic logic one_cycle();
        one_cycle = (ir_q == OP_NOP) || (is_alu_or && sfield != R_MEM)
                    || (is_copy && dfield != R_MEM && sfield != R_MEM)
                    || !(is_copy || is_alu_or || is_imm || ir_q == OP_JMP
                         || ir_q == OP_LDA || ir_q == OP_LHL
                         || ir_q == OP_LDXB || ir_q == OP_LDXD);
    endfunction : one_cycle

    // final machine cycle per instruction
    function automatic logic last_cycle();
        case (ir_q)
            OP_JMP:  last_cycle = (mcyc_q == 3'h3);
            OP_LDA:  last_cycle = (mcyc_q == 3'h4);
            OP_LHL:  last_cycle = (mcyc_q == 3'h5);
            default: last_cycle = is_imm && dfield == R_MEM
                                  ? (mcyc_q == 3'h3) : (mcyc_q == 3'h2);
        endcase
    endfunction : last_cycle

    // program counter, fetch address source and held bus address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q        <= 16'h0000;
            jmp_fetch_q <= 1'b0;
            ab_q        <= 16'h0000;
        end else if (run_q && st_q == ST_T2) begin
            if (mcyc_q == 3'h1) begin
                pc_q <= mbus.addr + 16'h0001;
                jmp_fetch_q <= 1'b0;
            end else if (!(mbus.addr != pc_q)) begin
                pc_q <= pc_q + 16'h0001;
            end
        end else if (run_q && st_q == ST_T3 && ir_q == OP_JMP
                     && mcyc_q == 3'h3) begin
            jmp_fetch_q <= 1'b1;
        end else if (run_q && st_q == ST_T1) begin
            ab_q <= ab_sel;
        end
    end

    // data latching: opcode, operands and address latches in t3, source in t4, latch step in t2
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_q  <= OP_NOP;
            tmp_q <= 8'h00;
            alo_q <= 8'h00;
            ahi_q <= 8'h00;
        end else if (run_q && st_q == ST_T3) begin
            if (mcyc_q == 3'h1) begin
                ir_q  <= mbus.rdata;
                tmp_q <= mbus.rdata;
            end else if ((ir_q == OP_JMP || ir_q == OP_LDA
                          || ir_q == OP_LHL) && mcyc_q == 3'h2) begin
                alo_q <= mbus.rdata;
            end else if ((ir_q == OP_JMP || ir_q == OP_LDA
                          || ir_q == OP_LHL) && mcyc_q == 3'h3) begin
                ahi_q <= mbus.rdata;
            end else if (mcyc_q == 3'h2) begin
                tmp_q <= mbus.rdata;
            end
        end else if (run_q && st_q == ST_T4 && mcyc_q == 3'h1) begin
            tmp_q <= src_val;
        end else if (run_q && st_q == ST_T2 && ir_q == OP_LHL
                     && mcyc_q == 3'h4) begin
            {ahi_q, alo_q} <= latch_addr + 16'h0001;
        end
    end

    // accumulator, registers and flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q        <= 8'h00;
            acc_shadow_q <= 8'h00;
            flag_q       <= 8'h00;
            or_pend_q    <= 1'b0;
            for (int i = 0; i < 8; i++) rf_q[i] <= 8'h00;
        end else if (run_q) begin
            if (st_q == ST_T2 && mcyc_q == 3'h1 && or_pend_q) begin
                acc_q <= or_res;
                flag_q[FL_Z]  <= (or_res == 8'h00);
                flag_q[FL_S]  <= or_res[7];
                flag_q[FL_P]  <= ~^or_res;
                flag_q[FL_CY] <= 1'b0;
                flag_q[FL_AC] <= 1'b0;
                or_pend_q     <= 1'b0;
            end
            if (st_q == ST_T4 && mcyc_q == 3'h1 && is_alu_or) begin
                acc_shadow_q <= acc_q;
                or_pend_q    <= (sfield != R_MEM);
            end
            if (st_q == ST_T3 && mcyc_q != 3'h1) begin
                if (is_alu_or) begin
                    or_pend_q <= 1'b1;
                end else if ((ir_q == OP_LDA && mcyc_q == 3'h4)
                             || ir_q == OP_LDXB || ir_q == OP_LDXD) begin
                    acc_q <= mbus.rdata;
                end else if (ir_q == OP_LHL && mcyc_q == 3'h4) begin
                    rf_q[R_BOT] <= mbus.rdata;
                end else if (ir_q == OP_LHL && mcyc_q == 3'h5) begin
                    rf_q[R_UP] <= mbus.rdata;
                end else if ((is_copy || (is_imm && mcyc_q == 3'h2))
                             && dfield != R_MEM) begin
                    if (dfield == R_ACC) acc_q <= mbus.rdata;
                    else rf_q[dfield] <= mbus.rdata;
                end
            end
            if (st_q == ST_T5 && is_copy) begin
                if (dfield == R_ACC) acc_q <= tmp_q;
                else rf_q[dfield] <= tmp_q;
            end
        end
    end

    // the or pending flag is set only by or_with_acc
    a_or_clears_cy: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (run_q && st_q == ST_T2 && mcyc_q == 3'h1 && or_pend_q)
        |=> !flag_q[FL_CY] && !flag_q[FL_AC])
        else $error("carry not cleared after or");
    a_nop_pc_step: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (run_q && st_q == ST_T2 && mcyc_q == 3'h1 && !jmp_fetch_q)
        |=> pc_q == $past(pc_q) + 16'h0001)
        else $error("pc did not step in fetch");
    a_jump_target: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (run_q && st_q == ST_T2 && mcyc_q == 3'h1 && jmp_fetch_q)
        |=> pc_q == $past(latch_addr) + 16'h0001)
        else $error("jump target wrong");
    a_or_zero_flag: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (run_q && st_q == ST_T2 && mcyc_q == 3'h1 && or_pend_q)
        |=> flag_q[FL_Z] == (acc_q == 8'h00))
        else $error("zero flag mismatch");
    a_fetch_no_write: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (mcyc_q == 3'h1) |-> !mbus.we)
        else $error("write in fetch cycle");
    a_lhl_next_addr: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (run_q && ir_q == OP_LHL && mcyc_q == 3'h4 && st_q == ST_T2)
        |=> latch_addr == $past(latch_addr) + 16'h0001)
        else $error("latch increment missing");
    a_flags_stable: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (!or_pend_q) |=> $stable(flag_q))
        else $error("flags changed without or");
    a_mem_uses_hl: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        mbus.we |-> mbus.addr == hl)
        else $error("memory write not at pair address");
endmodule : clmj_core
`default_nettype wire

// ---- clmj_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
// program and data memory, asynchronous read, clocked write, bus loaded
module clmj_mem
    import clmj_pkg::*;
(
    input  wire logic   core_clk,
    clmj_mem_if.mem     mp,
    input  wire logic   ld_we,
    input  wire logic [15:0] ld_addr,
    input  wire logic [7:0]  ld_data
);
    localparam int DEPTH = 256; // small image, address wraps
    logic [7:0] mem_q [DEPTH]; // storage array
    // write from core or from the loader
    always_ff @(posedge core_clk) begin
        if (ld_we) begin
            mem_q[ld_addr[7:0]] <= ld_data;
        end else if (mp.we) begin
            mem_q[mp.addr[7:0]] <= mp.wdata;
        end
    end
    // read path
    assign mp.rdata = mem_q[mp.addr[7:0]];
endmodule : clmj_mem
`default_nettype wire

// ---- clmj_mem_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// memory access channel between sequencer and memory array
interface clmj_mem_if;
    logic [15:0] addr;  // addr_pins
    logic [7:0]  wdata; // data_pins out
    logic [7:0]  rdata; // data_pins in
    logic        we;    // write strobe
    modport cpu (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface : clmj_mem_if
`default_nettype wire

// ---- clmj_pkg.sv ----
package clmj_pkg;
    // ahb transfer encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HSIZE_WORD    = 2'h2;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00; // run control
    localparam logic [7:0] OFF_STATUS = 8'h04; // acc, flags, state
    localparam logic [7:0] OFF_PC     = 8'h08; // program counter
    localparam logic [7:0] OFF_HL     = 8'h0c; // upper/bottom pair
    localparam logic [7:0] OFF_BC     = 8'h10; // b/c pair
    localparam logic [7:0] OFF_DE     = 8'h14; // d/e pair
    // opcodes
    localparam logic [7:0] OP_NOP  = 8'h00;
    localparam logic [7:0] OP_JMP  = 8'hc3;
    localparam logic [7:0] OP_LDA  = 8'h3a;
    localparam logic [7:0] OP_LDXB = 8'h0a;
    localparam logic [7:0] OP_LDXD = 8'h1a;
    localparam logic [7:0] OP_LHL  = 8'h2a;
    // register field codes
    localparam logic [2:0] R_B   = 3'h0;
    localparam logic [2:0] R_C   = 3'h1;
    localparam logic [2:0] R_D   = 3'h2;
    localparam logic [2:0] R_E   = 3'h3;
    localparam logic [2:0] R_UP  = 3'h4;
    localparam logic [2:0] R_BOT = 3'h5;
    localparam logic [2:0] R_MEM = 3'h6;
    localparam logic [2:0] R_ACC = 3'h7;
    // group prefixes in the top two opcode bits, plus or and immediate field codes
    localparam logic [1:0] GRP_COPY = 2'h1;
    localparam logic [1:0] GRP_ALU  = 2'h2;
    localparam logic [2:0] ALU_OR   = 3'h6;
    localparam logic [2:0] IMM_LOW  = 3'h6;
    // flag bit positions in the flag byte
    localparam int FL_CY = 0;
    localparam int FL_P  = 2;
    localparam int FL_AC = 4;
    localparam int FL_Z  = 6;
    localparam int FL_S  = 7;
    // processor states
    typedef enum logic [2:0] {
        ST_T1 = 3'h0, ST_T2 = 3'h1, ST_T3 = 3'h2,
        ST_T4 = 3'h3, ST_T5 = 3'h4, ST_HALT = 3'h5
    } clmj_tstate_t;
endpackage : clmj_pkg

// ---- tb_cpu_load_move_jump_or_exec.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_load_move_jump_or_exec
    import clmj_pkg::*;
;
    localparam int LIMIT = 20000;  // cycle ceiling for the whole run
    logic        core_clk;        // 250 mhz core clock
    logic        rst_n;           // async reset, active low
    logic        hsel;            // bus select
    logic [31:0] haddr;           // bus address
    logic [1:0]  htrans;          // bus transfer kind
    logic        hwrite;          // bus direction
    logic [2:0]  hsize;           // bus size
    logic [31:0] hwdata;          // bus write data
    logic [31:0] hrdata;          // bus read data
    logic        hreadyout;       // slave ready, also bus hready
    logic        hresp;           // slave response
    logic [15:0] addr_pins;       // memory address seen at the pins
    logic [7:0]  flags_out;       // flag byte
    int          bad_count = 0;   // mismatches
    int          cmp_count = 0;   // comparisons
    int          cyc = 0;         // cycle counter
    int          first_t [256];   // first cycle each low address showed
    logic        seen [256];      // address has shown since last clear
    logic [7:0]  img [];          // program image

    // clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    clmj_core clmj_core_inst (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .addr_pins (addr_pins),
        .flags_out (flags_out)
    );

    clmj_ahb_master clmj_ahb_master_inst (
        .core_clk  (core_clk),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata)
    );

    // timeout watch and first-appearance log of page-zero addresses
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            results();
        end
        if (rst_n === 1'b1 && addr_pins[15:8] === 8'h00 &&
            seen[addr_pins[7:0]] !== 1'b1) begin
            seen[addr_pins[7:0]] = 1'b1;
            first_t[addr_pins[7:0]] = cyc;
        end
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // register write, response must be okay
    task automatic wr_reg(input logic [7:0] off, input logic [31:0] v);
        logic [31:0] rd;
        logic        resp;
        clmj_ahb_master_inst.xfer(1'b1, off, v, rd, resp);
        chk({31'h0, resp}, 32'h0);
    endtask : wr_reg

    // register read, response must be okay
    task automatic rd_reg(input logic [7:0] off, output logic [31:0] v);
        logic resp;
        clmj_ahb_master_inst.xfer(1'b0, off, 32'h0, v, resp);
        chk({31'h0, resp}, 32'h0);
    endtask : rd_reg

    // one memory byte through the loader path of the control register
    task automatic poke(input logic [7:0] a, input logic [7:0] d);
        wr_reg(OFF_CTRL, {1'b1, 7'h00, 8'h00, a, d});
    endtask : poke

    // reset, load the image, run until the loop tail has been fetched
    task automatic run_img(input logic [7:0] tail);
        int n;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < img.size(); i++) poke(8'(i), img[i]);
        seen = '{default: 1'b0};
        wr_reg(OFF_CTRL, 32'h00000001);
        n = 0;
        while (seen[tail] !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chk({31'h0, seen[tail]}, 32'h1);
    endtask : run_img

    // immediate stores, pair loads, copies, direct loads, or, jump
    task automatic test_prog_a();
        logic [31:0] v;
        img = '{8'h00, 8'h06, 8'h00, 8'h0e, 8'h80, 8'h16, 8'h00, 8'h1e,
                8'h81, 8'h26, 8'h00, 8'h2e, 8'h82, 8'h36, 8'h5a, 8'h3e,
                8'h0f, 8'h0a, 8'h47, 8'h1a, 8'h57, 8'h4e, 8'h2a, 8'h83,
                8'h00, 8'h77, 8'h5e, 8'h3a, 8'h85, 8'h00, 8'hb1, 8'hc3,
                8'h30, 8'h00, 8'h3e, 8'hff};
        @(posedge core_clk);
        // operand bytes live past the image
        poke(8'h80, 8'ha5);
        poke(8'h81, 8'h3c);
        poke(8'h83, 8'h90);
        poke(8'h84, 8'h00);
        poke(8'h85, 8'h40);
        poke(8'h30, 8'hc3);
        poke(8'h31, 8'h30);
        poke(8'h32, 8'h00);
        run_img(8'h32);
        rd_reg(OFF_STATUS, v);
        chk({24'h0, v[7:0]}, 32'h5a);
        chk({24'h0, v[15:8] & 8'hd5}, 32'h04);
        rd_reg(OFF_BC, v);
        chk({16'h0, v[15:0]}, 32'ha55a);
        rd_reg(OFF_DE, v);
        chk({16'h0, v[15:0]}, 32'h3c3c);
        rd_reg(OFF_HL, v);
        chk({16'h0, v[15:0]}, 32'h0090);
        chk(32'(first_t[8'h12] - first_t[8'h11]), 32'd7);
        chk(32'(first_t[8'h19] - first_t[8'h16]), 32'd16);
        chk(32'(first_t[8'h30] - first_t[8'h1f]), 32'd10);
        chk({31'h0, seen[8'h22]}, 32'h0);
    endtask : test_prog_a

    // every or source, then flag-keeping instructions after it
    task automatic test_prog_b();
        logic [31:0] v;
        img = '{8'h3e, 8'h00, 8'h06, 8'h01, 8'h0e, 8'h02, 8'h16, 8'h04,
                8'h1e, 8'h08, 8'h26, 8'h80, 8'h2e, 8'h40, 8'h36, 8'h30,
                8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7,
                8'h5f, 8'h00, 8'h3e, 8'h11, 8'h48, 8'h2a, 8'h40, 8'h00,
                8'hc3, 8'h23, 8'h00, 8'hc3, 8'h23, 8'h00};
        @(posedge core_clk);
        poke(8'h41, 8'h00);
        run_img(8'h25);
        rd_reg(OFF_STATUS, v);
        chk({24'h0, v[7:0]}, 32'h11);
        chk({24'h0, v[15:8] & 8'hd5}, 32'h84);
        chk({24'h0, flags_out & 8'hd5}, 32'h84);
        rd_reg(OFF_BC, v);
        chk({16'h0, v[15:0]}, 32'h0101);
        rd_reg(OFF_DE, v);
        chk({16'h0, v[15:0]}, 32'h04ff);
        rd_reg(OFF_HL, v);
        chk({16'h0, v[15:0]}, 32'h0030);
        chk(32'(first_t[8'h1a] - first_t[8'h19]), 32'd4);
    endtask : test_prog_b

    // unmapped place and read-only pair register ignore writes
    task automatic test_bus();
        logic [31:0] v;
        rd_reg(8'h40, v);
        chk(v, 32'h0);
        wr_reg(8'h40, 32'h12345678);
        rd_reg(8'h40, v);
        chk(v, 32'h0);
        wr_reg(OFF_BC, 32'hffffffff);
        rd_reg(OFF_BC, v);
        chk({16'h0, v[15:0]}, 32'h0101);
    endtask : test_bus

    // counts, verdict, end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        rst_n = 1'b0;
        seen = '{default: 1'b0};
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        test_prog_a();
        test_prog_b();
        test_bus();
        results();
    end
endmodule : tb_cpu_load_move_jump_or_exec
`default_nettype wire
